// ===== mcsc_defs.vh
`ifndef MCSC_DEFS_VH
`define MCSC_DEFS_VH

// page numbers
`define MCSC_CTRL_PAGE 8'h70
`define MCSC_SNAP_PAGE 8'h71
`define MCSC_MIB_PAGE_FIRST 8'h20
`define MCSC_MIB_PAGE_LAST 8'h28

// offsets within a page
`define MCSC_CTRL_ADDR 8'h00
`define MCSC_SPI_DATA_FIRST 8'hf0
`define MCSC_SPI_DATA_LAST 8'hf7
`define MCSC_SPI_STATUS_ADDR 8'hfe
`define MCSC_PAGE_REG_ADDR 8'hff

// control register fields
`define MCSC_START_BIT 7
`define MCSC_MIRROR_BIT 6
`define MCSC_RSVD_MSB 5
`define MCSC_RSVD_LSB 4
`define MCSC_PORT_MSB 3
`define MCSC_PORT_LSB 0
`define MCSC_CTRL_RESET 8'h00
`define MCSC_PORT_RESET 4'h0
`define MCSC_START_RESET 1'b0
`define MCSC_MIRROR_RESET 1'b0

// port codes
`define MCSC_PORT_LAST_PHYS 4'h5
`define MCSC_MGMT_CPU_PORT 4'h8

// counter set size, in bytes, of one port
`define MCSC_CNT_BYTES 16
`define MCSC_CNT_IDX_W 4
`define MCSC_CNT_W 128

`endif

// ===== mcsc_store.v
`timescale 1ns/100ps
`default_nettype none
`include "mcsc_defs.vh"

module mcsc_store (
  input wire sys_clk_i,
  input wire rst_i,
  input wire capture_i,
  input wire [`MCSC_CNT_W-1:0] live_cnt_i,
  input wire [7:0] rd_addr_i,
  output wire [7:0] rd_data_o
);

  reg [7:0] snap_r [0:`MCSC_CNT_BYTES-1];
  integer i;

  // whole counter set loaded on one edge so every byte is from the same instant
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      for (i = 0; i < `MCSC_CNT_BYTES; i = i + 1)
        snap_r[i] <= 8'h00;
    end
    else if (capture_i)
    begin
      for (i = 0; i < `MCSC_CNT_BYTES; i = i + 1)
        snap_r[i] <= live_cnt_i[i*8 +: 8];
    end
  end

  // bytes past the counter set read as zero
  assign rd_data_o = (rd_addr_i < `MCSC_CNT_BYTES) ?
                     snap_r[rd_addr_i[`MCSC_CNT_IDX_W-1:0]] : 8'h00;

endmodule // mcsc_store

`default_nettype wire

// ===== mcsc_top.v
// Overview of operation
// - writing start bit begins capture, any view
// - start bit self-clears when copy is done
// - view bit set: counter page of the port in the port field shows snapshot, other counter pages live
// - view bit clear: counter pages show live
// - port field: 0-5 ports, 8 management port
// - snapshot page holds captured set, same layout
// - control page shows global bytes F0-F7, FE and FF
`timescale 1ns/100ps
`default_nettype none
`include "mcsc_defs.vh"

module mcsc_top (
  input wire sys_clk_i,
  input wire rst_i,
  input wire [7:0] reg_page_i,
  input wire [7:0] reg_addr_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_wdata_i,
  output reg [7:0] reg_rdata_o,
  output reg reg_rvalid_o,
  input wire [63:0] spi_data_i,
  input wire [7:0] spi_status_i,
  input wire [7:0] page_reg_i,
  input wire [7:0] live_page_byte_i,
  input wire [`MCSC_CNT_W-1:0] live_cnt_i,
  output reg [3:0] cnt_port_o,
  output reg snap_busy_o,
  output reg snap_done_o
);

  localparam ST_IDLE = 3'b001;
  localparam ST_SEL = 3'b010;
  localparam ST_CAP = 3'b100;

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg start_r;
  reg start_nxt;
  reg mirror_r;
  reg [3:0] port_r;
  reg [3:0] snap_port_r;
  reg [3:0] snap_port_nxt;
  reg [7:0] rdata_nxt;
  wire capture;
  wire ctrl_wr;
  wire [7:0] snap_rd_addr;
  wire [7:0] snap_byte;

  // counter page number to port code, all ones when not a counter page
  function [3:0] page_port;
    input [7:0] page;
    begin
      // counter pages start on a multiple of 16, so the low nibble is the port code
      if (page >= `MCSC_MIB_PAGE_FIRST && page <= `MCSC_MIB_PAGE_LAST)
        page_port = page[3:0];
      else
        page_port = 4'hf;
    end
  endfunction

  function is_global;
    input [7:0] addr;
    begin
      // the gap between the data bytes and the status byte stays unmapped
      is_global = (addr >= `MCSC_SPI_DATA_FIRST && addr <= `MCSC_SPI_DATA_LAST) ||
                  (addr == `MCSC_SPI_STATUS_ADDR) || (addr == `MCSC_PAGE_REG_ADDR);
    end
  endfunction

  assign ctrl_wr = reg_wr_i && (reg_page_i == `MCSC_CTRL_PAGE) &&
                   (reg_addr_i == `MCSC_CTRL_ADDR);
  assign capture = (state_r == ST_CAP);
  assign snap_rd_addr = reg_addr_i;

  mcsc_store u_store (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .capture_i(capture),
    .live_cnt_i(live_cnt_i),
    .rd_addr_i(snap_rd_addr),
    .rd_data_o(snap_byte)
  );

  // capture sequencer: select the port, let the counter mux settle, latch
  always @*
  begin
    state_nxt = state_r;
    start_nxt = start_r;
    snap_port_nxt = snap_port_r;
    case (state_r)
      ST_IDLE:
      begin
        if (ctrl_wr && reg_wdata_i[`MCSC_START_BIT])
        begin
          state_nxt = ST_SEL;
          start_nxt = 1'b1;
          snap_port_nxt = reg_wdata_i[`MCSC_PORT_MSB:`MCSC_PORT_LSB];
        end
      end
      ST_SEL:
        state_nxt = ST_CAP;
      ST_CAP:
      begin
        state_nxt = ST_IDLE;
        start_nxt = 1'b0;
      end
      default:
      begin
        state_nxt = ST_IDLE;
        start_nxt = 1'b0;
      end
    endcase
  end

  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_r <= ST_IDLE;
      start_r <= `MCSC_START_RESET;
      snap_port_r <= `MCSC_PORT_RESET;
      cnt_port_o <= `MCSC_PORT_RESET;
      snap_busy_o <= 1'b0;
      snap_done_o <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      start_r <= start_nxt;
      snap_port_r <= snap_port_nxt;
      cnt_port_o <= snap_port_nxt;
      snap_busy_o <= start_nxt;
      snap_done_o <= capture;
    end
  end

  // view bit and port field; writing while busy only changes these
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      mirror_r <= `MCSC_MIRROR_RESET;
      port_r <= `MCSC_PORT_RESET;
    end
    else if (ctrl_wr)
    begin
      mirror_r <= reg_wdata_i[`MCSC_MIRROR_BIT];
      port_r <= reg_wdata_i[`MCSC_PORT_MSB:`MCSC_PORT_LSB];
    end
  end

  // read path, answered one cycle after the read strobe
  always @*
  begin
    rdata_nxt = 8'h00;
    if ((reg_page_i == `MCSC_CTRL_PAGE || reg_page_i == `MCSC_SNAP_PAGE) &&
        is_global(reg_addr_i))
    begin
      if (reg_addr_i <= `MCSC_SPI_DATA_LAST)
        rdata_nxt = spi_data_i[reg_addr_i[2:0]*8 +: 8];
      else if (reg_addr_i == `MCSC_SPI_STATUS_ADDR)
        rdata_nxt = spi_status_i;
      else
        rdata_nxt = page_reg_i;
    end
    else if (reg_page_i == `MCSC_CTRL_PAGE)
    begin
      if (reg_addr_i == `MCSC_CTRL_ADDR)
        rdata_nxt = {start_r, mirror_r, 2'b00, port_r};
    end
    else if (reg_page_i == `MCSC_SNAP_PAGE)
      rdata_nxt = snap_byte;
    else if (page_port(reg_page_i) != 4'hf)
    begin
      if (mirror_r && page_port(reg_page_i) == port_r)
        rdata_nxt = snap_byte;
      else
        rdata_nxt = live_page_byte_i;
    end
  end

  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      reg_rdata_o <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end
    else
    begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i)
        reg_rdata_o <= rdata_nxt;
    end
  end

endmodule // mcsc_top

`default_nettype wire

// ===== mcsc_checker.sv
`timescale 1ns/100ps
`default_nettype none
module mcsc_checker (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic reg_rd_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_page_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire logic [7:0] spi_status_i,
  input wire logic [3:0] cnt_port_o,
  input wire logic snap_busy_o,
  input wire logic snap_done_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  wire logic ctl_rd = reg_rd_i && reg_page_i == 8'h70;
  wire logic [3:0] wport = reg_wdata_i[3:0];
  sequence s_copy;
    snap_busy_o [*2] ##1 (!snap_busy_o && snap_done_o);
  endsequence
  a_rd_answer: assert property
    (reg_rd_i |=> reg_rvalid_o) else $error("read not answered");
  a_start_takes: assert property (
    reg_wr_i && reg_page_i == 8'h70 && reg_addr_i == 8'h00 && reg_wdata_i[7] && !snap_busy_o
    |=> snap_busy_o && cnt_port_o == $past(wport)) else $error("capture not started");
  a_busy_clears: assert property
    ($rose(snap_busy_o) |-> s_copy) else $error("start bit not cleared");
  a_done_pulse: assert property
    (snap_done_o |=> !snap_done_o) else $error("done longer than one cycle");
  a_done_cause: assert property
    (snap_done_o |-> $fell(snap_busy_o)) else $error("done without capture");
  a_status_read: assert property
    (ctl_rd && reg_addr_i == 8'hfe |=> reg_rdata_o == $past(spi_status_i)) else $error("bad status");
  a_rsvd_zero: assert property
    (ctl_rd && reg_addr_i == 8'h00 |=> reg_rdata_o[5:4] == 2'b00) else $error("reserved bits set");
  a_unmapped_zero: assert property (
    ctl_rd && reg_addr_i inside {[8'h01:8'hef]} |=> reg_rdata_o == 8'h00) else $error("unmapped read");
  a_gap_zero: assert property (
    ctl_rd && reg_addr_i inside {[8'hf8:8'hfd]} |=> reg_rdata_o == 8'h00) else $error("gap read");
endmodule // mcsc_checker
bind mcsc_top mcsc_checker u_chk (
  .sys_clk_i(sys_clk_i),
  .rst_i(rst_i),
  .reg_rd_i(reg_rd_i),
  .reg_wr_i(reg_wr_i),
  .reg_page_i(reg_page_i),
  .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o),
  .reg_rvalid_o(reg_rvalid_o),
  .spi_status_i(spi_status_i),
  .cnt_port_o(cnt_port_o),
  .snap_busy_o(snap_busy_o),
  .snap_done_o(snap_done_o)
);
`default_nettype wire

// ===== mcsc_top_bench.sv
`timescale 1ns/100ps
`default_nettype none
module mcsc_top_bench;
  logic sys_clk_i = 0, rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, v;
  logic [7:0] reg_page_i = 0, reg_addr_i = 0, reg_wdata_i = 0;
  logic [7:0] spi_status_i, page_reg_i, live_page_byte_i;
  logic [63:0] spi_data_i;
  logic [127:0] live_cnt_i = 0, snap;
  logic [3:0] p;
  logic [7:0] q[$];
  wire [7:0] reg_rdata_o;
  wire [3:0] cnt_port_o;
  wire reg_rvalid_o, snap_busy_o, snap_done_o;
  integer seed = 32'h0676, fails = 0, samples_checked = 0, i, k;
  mcsc_top u_dut (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .reg_page_i(reg_page_i),
    .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o),
    .spi_data_i(spi_data_i),
    .spi_status_i(spi_status_i),
    .page_reg_i(page_reg_i),
    .live_page_byte_i(live_page_byte_i),
    .live_cnt_i(live_cnt_i),
    .cnt_port_o(cnt_port_o),
    .snap_busy_o(snap_busy_o),
    .snap_done_o(snap_done_o)
  );
  always #4 sys_clk_i = ~sys_clk_i;
  task chk(input string n, input [7:0] e, g);
    samples_checked++;
    if (e !== g) begin fails++; $display("[ERR] %s exp %h got %h", n, e, g); end
  endtask
  always @(negedge sys_clk_i) if (reg_rvalid_o === 1'b1) chk("rdata", q.pop_front(), reg_rdata_o);
  // one access; a read notes its expected byte
  task acc(input [7:0] pg, ad, wd, input w, input [7:0] e);
    @(posedge sys_clk_i) #1;
    {reg_page_i, reg_addr_i, reg_wdata_i, reg_wr_i, reg_rd_i} = {pg, ad, wd, w, !w};
    if (!w) q.push_back(e);
    @(posedge sys_clk_i) #1;
    {reg_wr_i, reg_rd_i} = 2'b00;
  endtask
  task results;
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // whole run needs about 3 us
  initial begin #200000; fails++; results; end
  initial
  begin
    spi_data_i = {$random(seed), $random(seed)};
    {spi_status_i, page_reg_i, live_page_byte_i} = $random(seed);
    repeat (10) @(posedge sys_clk_i);
    #1 rst_i = 0;
    acc(8'h70, 8'h00, 0, 0, 8'h00);
    acc(8'h70, 8'h01, 0, 0, 8'h00);
    acc(8'h70, 8'hf0, 8'h5a, 1, 0);
    for (k = 0; k < 10; k++) acc(8'h70 + k[0], k < 8 ? 8'hf0 + k : 8'hf6 + k, 0, 0,
      k < 8 ? spi_data_i[8*k +: 8] : k == 8 ? spi_status_i : page_reg_i);
    acc(8'h71, 8'hfa, 0, 0, 8'h00);
    $display("test globals done");
    for (i = 0; i < 7; i++)
    begin
      p = i == 6 ? 4'h8 : i;
      v = i[0];
      live_cnt_i = {$random(seed), $random(seed), $random(seed), $random(seed)};
      snap = live_cnt_i;
      acc(8'h70, 8'h00, {1'b1, v, 2'b00, p}, 1, 0);
      chk("busy", 1, snap_busy_o);
      for (k = 0; k < 20 && snap_done_o !== 1'b1; k++) @(negedge sys_clk_i);
      chk("done", 1, snap_done_o);
      chk("port", p, cnt_port_o);
      @(posedge sys_clk_i) #1 live_cnt_i = ~snap;
      acc(8'h70, 8'h00, 0, 0, {1'b0, v, 2'b00, p});
      for (k = 0; k < 17; k++) acc(8'h71, k, 0, 0, k < 16 ? snap[8*k +: 8] : 8'h00);
      acc(p == 8 ? 8'h28 : 8'h20 + p, 8'h05, 0, 0, v ? snap[47:40] : live_page_byte_i);
      acc(p == 0 ? 8'h21 : 8'h20, 8'h05, 0, 0, live_page_byte_i);
      $display("test capture port %0d done", p);
    end
    // let the last read answer reach the watcher before the verdict
    repeat (2) @(posedge sys_clk_i);
    results;
  end
endmodule // mcsc_top_bench
`default_nettype wire
